/* File: include/ams_pkg.sv */
// Package: constants and carrier types for the ADC multiplexer sequencer
package ams_pkg;

  // ---------------------------------------------------------------------
  // Widths and alignment
  // ---------------------------------------------------------------------
  localparam int RAW_W    = 22;
  localparam int RES_W    = 32;
  localparam int SHIFT    = 9;
  localparam int CONV_CYC = 16;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [RES_W-1:0] RES_RST  = 32'h0000_0000;
  localparam logic [4:0]       CNT_RST  = 5'h00;

  // ---------------------------------------------------------------------
  // Multiplexer slots, one-hot
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    AMS_SLOT_I1 = 4'h1,
    AMS_SLOT_V1 = 4'h2,
    AMS_SLOT_I2 = 4'h4,
    AMS_SLOT_V2 = 4'h8
  } ams_slot_t;

  // Converter handshake toward the analog modulator and decimator
  typedef struct packed {
    logic             done;
    logic [RAW_W-1:0] data;
  } ams_conv_t;

  // Aligned pair handed to the compute engine
  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] current;
    logic [RES_W-1:0] voltage;
  } ams_pair_t;

endpackage

/* File: design/ams_seq.sv */
// Design: multiplexer sequencer, result registers, delay alignment, pins
`timescale 1ns/1ps
// Behaviour
// - Inputs routed one by one into converter
// - Frame holds four slots, two currents, voltages
// - Current sampled first, its voltage next
// - Conversions start automatically, no host command
// - Finished conversion written to slot's register
// - Each input has its own result register
// - Result stored shifted left by nine bits
// - Current delayed one interval to align voltage
// - Active-low interrupt output signals host events
// - Multi-use pins are I/O, else energy pulses
module ams_seq (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Converter
  input  wire ams_pkg::ams_conv_t conv_in,
  output      logic               conv_start,
  output      logic [3:0]         mux_sel,
  // Compute engine
  output      logic [31:0]        first_current_result,
  output      logic [31:0]        second_current_result,
  output      logic [31:0]        first_voltage_result,
  output      logic [31:0]        second_voltage_result,
  output      ams_pkg::ams_pair_t ce_pair,
  // Event and pins
  input  wire logic               event_req,
  input  wire logic [1:0]         pulse_sel,
  input  wire logic               real_energy_pulse,
  input  wire logic               reactive_energy_pulse,
  input  wire logic [1:0]         gpio_out,
  input  wire logic [1:0]         gpio_oe_n,
  output      logic               host_irq_n,
  output      logic               multiuse_pin0,
  output      logic               multiuse_pin1,
  output      logic [1:0]         multiuse_oe_n
);

  // -------------------------------------------------------------------
  // Slot sequencer
  // -------------------------------------------------------------------
  ams_pkg::ams_slot_t slot;
  ams_pkg::ams_slot_t next_slot;
  logic               busy;
  logic [4:0]         tmo;

  always_comb begin
    unique case (slot)
      ams_pkg::AMS_SLOT_I1: next_slot = ams_pkg::AMS_SLOT_V1;
      ams_pkg::AMS_SLOT_V1: next_slot = ams_pkg::AMS_SLOT_I2;
      ams_pkg::AMS_SLOT_I2: next_slot = ams_pkg::AMS_SLOT_V2;
      ams_pkg::AMS_SLOT_V2: next_slot = ams_pkg::AMS_SLOT_I1;
      default:              next_slot = ams_pkg::AMS_SLOT_I1;
    endcase
  end

  // The sequencer issues every start itself; no host command exists.
  // A lost done is recovered by a timeout so the frame never stalls,
  // at the cost of retrying the same slot instead of skipping it.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= !busy;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (!busy) begin
      busy <= 1'b1;
    end else if (conv_in.done) begin
      busy <= 1'b0;
    end else if (tmo == 5'(ams_pkg::CONV_CYC - 1)) begin
      busy <= 1'b0;
    end
  end

  // Timeout counter only runs while a conversion is outstanding
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tmo <= ams_pkg::CNT_RST;
    end else if (!busy) begin
      tmo <= ams_pkg::CNT_RST;
    end else if (!conv_in.done) begin
      tmo <= tmo + 5'h01;
    end
  end

  // Slot advances only on a taken done, so a retry repeats the slot
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slot <= ams_pkg::AMS_SLOT_I1;
    end else if (busy && conv_in.done) begin
      slot <= next_slot;
    end
  end

  // Select lags the slot by a cycle; it names the slot being converted
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mux_sel <= ams_pkg::AMS_SLOT_I1;
    end else begin
      mux_sel <= slot;
    end
  end

  // -------------------------------------------------------------------
  // Result registers
  // -------------------------------------------------------------------
  logic [31:0] aligned;
  logic        store;

  // Bit 31 stays zero: 22 data bits and the 9-bit shift fill 31 bits
  assign store   = busy && conv_in.done;
  assign aligned = {1'b0, conv_in.data, 9'h000};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      first_current_result  <= ams_pkg::RES_RST;
      second_current_result <= ams_pkg::RES_RST;
      first_voltage_result  <= ams_pkg::RES_RST;
      second_voltage_result <= ams_pkg::RES_RST;
    end else if (store) begin
      unique case (slot)
        ams_pkg::AMS_SLOT_I1: first_current_result  <= aligned;
        ams_pkg::AMS_SLOT_V1: first_voltage_result  <= aligned;
        ams_pkg::AMS_SLOT_I2: second_current_result <= aligned;
        ams_pkg::AMS_SLOT_V2: second_voltage_result <= aligned;
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Delay alignment toward the compute engine
  // -------------------------------------------------------------------
  // Current is held one full interval; the voltage allpass lives in
  // the compute engine, so only the integer delay is done here.
  logic [31:0] cur_dly;
  logic        is_volt;
  logic        is_cur;

  assign is_volt = (slot == ams_pkg::AMS_SLOT_V1) ||
                   (slot == ams_pkg::AMS_SLOT_V2);
  assign is_cur  = (slot == ams_pkg::AMS_SLOT_I1) ||
                   (slot == ams_pkg::AMS_SLOT_I2);

  // Only current slots load the delay stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_dly <= ams_pkg::RES_RST;
    end else if (store && is_cur) begin
      cur_dly <= aligned;
    end
  end

  // Valid pulses one cycle; data holds until the next voltage slot
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ce_pair <= '0;
    end else begin
      ce_pair.valid <= store && is_volt;
      if (store && is_volt) begin
        ce_pair.current <= cur_dly;
        ce_pair.voltage <= aligned;
      end
    end
  end

  // -------------------------------------------------------------------
  // Interrupt and multi-use pins
  // -------------------------------------------------------------------
  // Registered so the pin cannot glitch while the event source settles
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_irq_n <= 1'b1;
    end else begin
      host_irq_n <= !event_req;
    end
  end

  // Pins float after reset until software enables them.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      multiuse_pin0 <= 1'b0;
    end else begin
      multiuse_pin0 <= pulse_sel[0] ? real_energy_pulse
                                    : gpio_out[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      multiuse_pin1 <= 1'b0;
    end else begin
      multiuse_pin1 <= pulse_sel[1] ? reactive_energy_pulse
                                    : gpio_out[1];
    end
  end

  // A selected pulse function always drives its pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      multiuse_oe_n[0] <= 1'b1;
    end else begin
      multiuse_oe_n[0] <= pulse_sel[0] ? 1'b0 : gpio_oe_n[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      multiuse_oe_n[1] <= 1'b1;
    end else begin
      multiuse_oe_n[1] <= pulse_sel[1] ? 1'b0 : gpio_oe_n[1];
    end
  end

endmodule

/* File: test/ams_conv_model.sv */
// Partner: converter answering each start after a set delay
`timescale 1ns/1ps
module ams_conv_model (
  // Clock and control
  input  wire logic         ref_clk,
  input  wire logic         conv_start,
  input  wire logic [4:0]   dly,
  // Result
  output ams_pkg::ams_conv_t conv
);
  logic       busy = 1'b0;
  logic [4:0] cnt  = 5'h00;
  initial conv = '0;
  // Data walks every cycle so a late capture never matches by luck
  always @(posedge ref_clk) begin
    conv.data <= conv.data + 22'h0A5A5B;
    conv.done <= 1'b0;
    if (conv_start) begin
      busy <= 1'b1;
      cnt  <= dly;
    end else if (busy) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h00) begin
        busy      <= 1'b0;
        conv.done <= 1'b1;
      end
    end
  end
endmodule

/* File: test/ams_monitor.sv */
// Checker: start pacing, slot order, storage, pairing, event
`timescale 1ns/1ps
module ams_monitor (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst_n,
  // Watched ports
  input wire ams_pkg::ams_conv_t conv_in,
  input wire logic               conv_start,
  input wire logic [3:0]         mux_sel,
  input wire logic [31:0]        first_current_result,
  input wire ams_pkg::ams_pair_t ce_pair,
  input wire logic               event_req,
  input wire logic               host_irq_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A done in the start cycle is left out of fin, though the sequencer takes it
  logic fin;
  assign fin = conv_in.done && !conv_start;
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start too long");
  a_start_gap: assert property (fin |=> !conv_start ##1 conv_start)
    else $error("start not relaunched");
  a_slot_onehot: assert property ($onehot(mux_sel))
    else $error("slot not one-hot");
  // The select lags the slot by one cycle, so the step shows two later
  a_slot_order: assert property (fin |-> ##2
    mux_sel == {$past(mux_sel[2:0], 2), $past(mux_sel[3], 2)})
    else $error("slot order");
  a_result_store: assert property (fin && mux_sel[0] |=>
    first_current_result == {1'b0, $past(conv_in.data), 9'h000})
    else $error("result store");
  a_pair_valid: assert property (fin |=>
    ce_pair.valid == |($past(mux_sel) & 4'hA))
    else $error("pair valid");
  a_pair_idle: assert property (!fin |=> !ce_pair.valid)
    else $error("stray pair");
  a_irq_event: assert property ($rose(event_req) |=> !host_irq_n)
    else $error("irq missing");
  cover property (fin && mux_sel[3]);
  cover property (ce_pair.valid);
  cover property (!host_irq_n);
endmodule

/* File: test/tb_adc_mux_sample_sequencer.sv */
// Bench: frames, retry, event and multi-use pins
`timescale 1ns/1ps
module tb_adc_mux_sample_sequencer;
  logic ref_clk = 1'b0, rst_n = 1'b0, event_req = 1'b0, conv_start;
  logic real_energy_pulse = 1'b1, reactive_energy_pulse = 1'b0;
  logic host_irq_n, multiuse_pin0, multiuse_pin1;
  logic [1:0] pulse_sel = 2'h0, gpio_out = 2'h2, gpio_oe_n = 2'h1;
  logic [1:0] multiuse_oe_n;
  logic [3:0] mux_sel;
  logic [4:0] dly = 5'h03;
  logic [31:0] res [4];
  ams_pkg::ams_conv_t conv;
  ams_pkg::ams_pair_t ce_pair;
  int n_mismatch = 0, tests_run = 0;
  ams_seq dut_u (.conv_in(conv), .first_current_result(res[0]),
    .first_voltage_result(res[1]), .second_current_result(res[2]),
    .second_voltage_result(res[3]), .*);
  ams_conv_model part_u (.ref_clk, .conv_start, .dly, .conv);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wait_done;
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      #1;
      if (conv.done === 1'b1) return;
    end
    n_mismatch++;
    complete_run();
  endtask
  task automatic t_frame;
    logic [31:0] e, cur;
    for (int i = 0; i < 8; i++) begin
      wait_done();
      e = {1'b0, conv.data, 9'h000};
      chk(mux_sel, 32'h1 << (i % 4));
      @(posedge ref_clk);
      #1 chk(res[i % 4], e);
      chk(ce_pair.valid, i % 2);
      if (i % 2) chk(ce_pair.current, cur);
      if (i % 2) chk(ce_pair.voltage, e);
      cur = e;
    end
  endtask
  task automatic t_retry;
    logic [3:0] m;
    int s = 0;
    @(posedge ref_clk);
    dly <= 5'h1F;
    repeat (8) @(posedge ref_clk);
    #1 m = mux_sel;
    repeat (40) begin
      @(posedge ref_clk);
      #1 s += conv_start;
    end
    chk(mux_sel, m);
    chk(s > 1, 1);
    @(posedge ref_clk);
    dly <= 5'h02;
  endtask
  task automatic t_pins;
    logic [1:0] sv [3] = '{2'h3, 2'h0, 2'h1};
    logic [4:0] ev [3] = '{5'h01, 5'h06, 5'h13};
    for (int j = 0; j < 3; j++) begin
      @(posedge ref_clk);
      pulse_sel <= sv[j];
      event_req <= (j != 2);
      repeat (2) @(posedge ref_clk);
      #1 chk({host_irq_n, multiuse_oe_n, multiuse_pin1, multiuse_pin0},
        ev[j]);
    end
  endtask
  initial begin
    @(posedge ref_clk);
    #1 chk({host_irq_n, multiuse_oe_n, mux_sel}, 32'h71);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    t_frame();
    t_retry();
    t_pins();
    complete_run();
  end
endmodule
bind ams_seq ams_monitor mon_u (.*);
